// ===== core/lrp_params.svh
// offsets, field positions, reset values and timing counts of the reset/power block
`ifndef LRP_PARAMS_SVH
`define LRP_PARAMS_SVH

`define LRP_OFF_EXT_RST     8'h00
`define LRP_OFF_LINK_SIX    8'h04
`define LRP_OFF_LINK_SEVEN  8'h08
`define LRP_OFF_PWR_OPT     8'h0C
`define LRP_OFF_BM_A        8'h10
`define LRP_OFF_BM_B        8'h14
`define LRP_OFF_CCR_ZERO    8'h18
`define LRP_OFF_CCR_ONE     8'h1C
`define LRP_OFF_STATUS      8'h20
`define LRP_OFF_SRP_BASE    8'h40
`define LRP_SRP_SPAN_BITS   5

`define LRP_BIT_EXT_RST     0
`define LRP_BIT_HOLD        7
`define LRP_BIT_LOW_POWER_REQUEST_N_N      5
`define LRP_BIT_OSC_SEL     4
`define LRP_BIT_CARD_SOFT_RESET      7
`define LRP_BIT_CARD_POWER_DOWN      2

`define LRP_RST_LINK_SIX    8'h80
`define LRP_RST_LINK_SEVEN  8'h20
`define LRP_RST_ZERO        8'h00

`define LRP_CLK_MHZ         20
`define LRP_STARTUP_WAIT_US 200
`define LRP_STARTUP_CYC     (`LRP_STARTUP_WAIT_US * `LRP_CLK_MHZ)
`define LRP_OSC_SETTLE_US   2
`define LRP_OSC_SETTLE_CYC  (`LRP_OSC_SETTLE_US * `LRP_CLK_MHZ)
`define LRP_CLK_SETTLE_CYC  4
`define LRP_INIT_PULSE_CYC  8

`endif

// ===== core/lrp_pkg.sv
// types shared by the reset/power block
package lrp_pkg;

  typedef enum logic [1:0] {
    LRP_MODE_ISA = 2'h0,
    LRP_MODE_GPB = 2'h1,
    LRP_MODE_PCC = 2'h2,
    LRP_MODE_RSV = 2'h3
  } lrp_bus_mode_t;

  typedef enum logic [4:0] {
    LRP_ST_RUN      = 5'h01,
    LRP_ST_GATED    = 5'h02,
    LRP_ST_OSC_OFF  = 5'h04,
    LRP_ST_OSC_WAIT = 5'h08,
    LRP_ST_CLK_WAIT = 5'h10
  } lrp_pwr_state_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } lrp_wreq_t;

  typedef struct packed {
    logic           osc_run;
    logic           clk_run;
    logic           clk_stable;
    lrp_pwr_state_t state;
  } lrp_clk_stat_t;

endpackage : lrp_pkg

// ===== core/lrp_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time, answer one cycle later
module lrp_axil_slave
  import lrp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output lrp_wreq_t        wreq,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        wr_mapped,
  input  wire logic        rd_mapped
);
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire both_in = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_go   = ~s_axi_arready & ~s_axi_rvalid;

  logic [7:0] araddr_r;

  assign wreq    = '{en: wr_go_r, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
  assign rd_addr = araddr_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      wr_go_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end
    else
    begin
      wr_go_r <= 1'b0;
      if (aw_take)
      begin
        s_axi_awready <= 1'b0;
        awaddr_r      <= s_axi_awaddr;
      end
      if (w_take)
      begin
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (both_in)
      begin
        // unmapped writes are dropped and answered with SLVERR
        wr_go_r      <= wr_mapped;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      araddr_r      <= 8'h00;
    end
    else
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        araddr_r      <= s_axi_araddr;
      end
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mapped ? rd_data : 32'h0000_0000;
        s_axi_rresp  <= rd_mapped ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : lrp_axil_slave

// ===== core/lrp_clk_seq.sv
// oscillator and clock-gate sequencer for standby and shutdown
`include "lrp_params.svh"
module lrp_clk_seq
  import lrp_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = `LRP_OSC_SETTLE_CYC,
  parameter int CLK_SETTLE_CYC = `LRP_CLK_SETTLE_CYC
)
(
  input  wire logic    clock,
  input  wire logic    srst,
  input  wire logic    low_power_req,
  input  wire logic    osc_stop_sel,
  output lrp_clk_stat_t stat
);
  lrp_pwr_state_t state_r;
  lrp_pwr_state_t state_nxt;
  logic [11:0]    cnt_r;
  logic [11:0]    cnt_nxt;
  logic           osc_r;
  logic           clk_r;
  logic           stable_r;

  wire cnt_done = cnt_r == 12'h000;

  assign stat = '{osc_run: osc_r, clk_run: clk_r, clk_stable: stable_r, state: state_r};

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? 12'h000 : cnt_r - 12'h001;
    case (state_r)
      LRP_ST_RUN:
        if (low_power_req)
          state_nxt = osc_stop_sel ? LRP_ST_OSC_OFF : LRP_ST_GATED;
      LRP_ST_GATED:
        if (!low_power_req)
        begin
          state_nxt = LRP_ST_CLK_WAIT;
          cnt_nxt   = 12'(CLK_SETTLE_CYC - 1);
        end
        else if (osc_stop_sel)
          state_nxt = LRP_ST_OSC_OFF;
      LRP_ST_OSC_OFF:
        if (!low_power_req)
        begin
          state_nxt = LRP_ST_OSC_WAIT;
          cnt_nxt   = 12'(OSC_SETTLE_CYC - 1);
        end
      LRP_ST_OSC_WAIT:
        if (cnt_done)
        begin
          state_nxt = LRP_ST_CLK_WAIT;
          cnt_nxt   = 12'(CLK_SETTLE_CYC - 1);
        end
      LRP_ST_CLK_WAIT:
        if (cnt_done)
          state_nxt = LRP_ST_RUN;
      default:
        state_nxt = LRP_ST_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r  <= LRP_ST_RUN;
      cnt_r    <= 12'h000;
      osc_r    <= 1'b1;
      clk_r    <= 1'b1;
      stable_r <= 1'b1;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      // oscillator first, then clocks, then logic: never run on an unsettled clock
      osc_r    <= state_nxt != LRP_ST_OSC_OFF;
      clk_r    <= state_nxt == LRP_ST_RUN || state_nxt == LRP_ST_CLK_WAIT;
      stable_r <= state_nxt == LRP_ST_RUN;
    end
  end

endmodule : lrp_clk_seq

// ===== core/lrp_top.sv
// reset and power-management control of the LAN controller, AXI4-Lite register access
`include "lrp_params.svh"
module lrp_top
  import lrp_pkg::*;
#(
  parameter int STARTUP_CYC    = `LRP_STARTUP_CYC,
  parameter int OSC_SETTLE_CYC = `LRP_OSC_SETTLE_CYC,
  parameter int CLK_SETTLE_CYC = `LRP_CLK_SETTLE_CYC,
  parameter int INIT_PULSE_CYC = `LRP_INIT_PULSE_CYC
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [1:0]  bus_mode_pin,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             lan_ctrl_init,
  output logic             xcvr_init,
  output logic             xcvr_power_down,
  output logic             card_cfg_init,
  output logic             mem_card_if_sel,
  output logic             osc_enable,
  output logic             clk_enable,
  output logic             startup_ready,
  output logic [7:0]       buffer_mgmt_reg_a,
  output logic [7:0]       buffer_mgmt_reg_b
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = addr == off;
  endfunction : hit

  function automatic logic [7:0] merge(input logic [7:0] old, input lrp_wreq_t w);
    merge = w.strb[0] ? w.data[7:0] : old;
  endfunction : merge

  lrp_wreq_t     wreq;
  lrp_clk_stat_t cstat;
  logic [7:0]    rd_addr;
  logic [31:0]   rd_data;
  logic [1:0]    mode_meta_r;
  logic [1:0]    mode_r;
  logic [7:0]    link_six_r;
  logic [7:0]    link_six_nxt;
  logic [7:0]    link_seven_r;
  logic [7:0]    link_seven_nxt;
  logic [7:0]    pwr_opt_r;
  logic [7:0]    pwr_opt_nxt;
  logic [7:0]    bm_a_nxt;
  logic [7:0]    bm_b_nxt;
  logic [7:0]    ccr_zero_r;
  logic [7:0]    ccr_zero_nxt;
  logic [7:0]    ccr_one_r;
  logic [7:0]    ccr_one_nxt;
  logic [7:0]    init_cnt_r;
  logic [12:0]   start_cnt_r;
  logic          io_card_sel;
  logic          wr_mapped;
  logic          rd_mapped;

  lrp_axil_slave u_bus (
    .clock         (clock),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wreq          (wreq),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .wr_mapped     (wr_mapped),
    .rd_mapped     (rd_mapped)
  );

  // mode straps come from pins
  wire is_isa  = mode_r == LRP_MODE_ISA;
  wire is_card = mode_r == LRP_MODE_PCC;

  // address decode for the pending write (held in the slave until the answer is taken)
  wire wa_ext   = hit(wreq.addr, `LRP_OFF_EXT_RST);
  wire wa_six   = hit(wreq.addr, `LRP_OFF_LINK_SIX);
  wire wa_seven = hit(wreq.addr, `LRP_OFF_LINK_SEVEN);
  wire wa_popt  = hit(wreq.addr, `LRP_OFF_PWR_OPT);
  wire wa_bma   = hit(wreq.addr, `LRP_OFF_BM_A);
  wire wa_bmb   = hit(wreq.addr, `LRP_OFF_BM_B);
  wire wa_card_config_reg_zero  = hit(wreq.addr, `LRP_OFF_CCR_ZERO);
  wire wa_card_config_reg_one  = hit(wreq.addr, `LRP_OFF_CCR_ONE);
  wire wa_srp   = wreq.addr[7:`LRP_SRP_SPAN_BITS] ==
                  3'(`LRP_OFF_SRP_BASE >> `LRP_SRP_SPAN_BITS);
  wire wa_card  = wa_card_config_reg_zero | wa_card_config_reg_one;
  wire wa_stat  = hit(wreq.addr, `LRP_OFF_STATUS);

  // soft reset ports and card registers exist only in their own bus mode
  assign wr_mapped = wa_ext | wa_six | wa_seven | wa_popt | wa_bma | wa_bmb | wa_stat
                 | (wa_srp & is_isa) | (wa_card & is_card);

  wire ra_srp  = rd_addr[7:`LRP_SRP_SPAN_BITS] == 3'(`LRP_OFF_SRP_BASE >> `LRP_SRP_SPAN_BITS);
  wire ra_card = hit(rd_addr, `LRP_OFF_CCR_ZERO) | hit(rd_addr, `LRP_OFF_CCR_ONE);
  assign rd_mapped = hit(rd_addr, `LRP_OFF_EXT_RST) | hit(rd_addr, `LRP_OFF_LINK_SIX)
                 | hit(rd_addr, `LRP_OFF_LINK_SEVEN) | hit(rd_addr, `LRP_OFF_PWR_OPT)
                 | hit(rd_addr, `LRP_OFF_BM_A) | hit(rd_addr, `LRP_OFF_BM_B)
                 | hit(rd_addr, `LRP_OFF_STATUS) | (ra_srp & is_isa)
                 | (ra_card & is_card);

  // reset sources
  wire ext_rst   = wreq.en & wa_ext & wreq.strb[0]
                 & wreq.data[`LRP_BIT_EXT_RST];
  wire port_rst  = wreq.en & wa_srp & is_isa;
  wire card_srst = is_card & ccr_zero_r[`LRP_BIT_CARD_SOFT_RESET];
  wire full_rst  = ext_rst | card_srst;
  wire ctrl_rst  = full_rst | port_rst;

  wire hold      = link_six_r[`LRP_BIT_HOLD];
  wire low_pwr   = ~link_seven_r[`LRP_BIT_LOW_POWER_REQUEST_N_N];
  wire init_act  = ctrl_rst | (init_cnt_r != 8'h00);

  lrp_clk_seq #(
    .OSC_SETTLE_CYC (OSC_SETTLE_CYC),
    .CLK_SETTLE_CYC (CLK_SETTLE_CYC)
  ) u_seq (
    .clock         (clock),
    .srst          (srst),
    .low_power_req (low_pwr),
    .osc_stop_sel  (pwr_opt_r[`LRP_BIT_OSC_SEL]),
    .stat          (cstat)
  );

  assign osc_enable = cstat.osc_run;
  assign clk_enable = cstat.clk_run;

  always_comb
  begin
    link_six_nxt   = link_six_r;
    link_seven_nxt = link_seven_r;
    pwr_opt_nxt    = pwr_opt_r;
    bm_a_nxt       = buffer_mgmt_reg_a;
    bm_b_nxt       = buffer_mgmt_reg_b;
    ccr_zero_nxt   = ccr_zero_r;
    ccr_one_nxt    = ccr_one_r;
    if (wreq.en)
    begin
      if (wa_six)
        link_six_nxt = merge(link_six_r, wreq);
      if (wa_seven)
        link_seven_nxt = merge(link_seven_r, wreq);
      if (wa_popt)
        pwr_opt_nxt = merge(pwr_opt_r, wreq);
      if (wa_bma)
        bm_a_nxt = merge(buffer_mgmt_reg_a, wreq);
      if (wa_bmb)
        bm_b_nxt = merge(buffer_mgmt_reg_b, wreq);
      if (wa_card_config_reg_zero & is_card)
        ccr_zero_nxt = merge(ccr_zero_r, wreq);
      if (wa_card_config_reg_one & is_card)
        ccr_one_nxt = merge(ccr_one_r, wreq);
    end
    // controller registers go to reset values; the buffer pair survives port resets
    if (ctrl_rst)
    begin
      link_six_nxt   = `LRP_RST_LINK_SIX;
      link_seven_nxt = `LRP_RST_LINK_SEVEN;
      pwr_opt_nxt    = `LRP_RST_ZERO;
    end
    if (full_rst)
    begin
      bm_a_nxt    = `LRP_RST_ZERO;
      bm_b_nxt    = `LRP_RST_ZERO;
      ccr_one_nxt = `LRP_RST_ZERO;
    end
    // soft-reset bit clears the rest of its register but not itself
    if (card_srst)
      ccr_zero_nxt = ccr_zero_nxt & (8'h01 << `LRP_BIT_CARD_SOFT_RESET);
    if (ext_rst)
      ccr_zero_nxt = `LRP_RST_ZERO;
    // in card mode the standby bit is slaved to card power-down; host writes to it are lost
    if (is_card)
      link_seven_nxt[`LRP_BIT_LOW_POWER_REQUEST_N_N] = ~ccr_one_nxt[`LRP_BIT_CARD_POWER_DOWN];
  end

  always_ff @(posedge clock)
  begin
    mode_meta_r <= bus_mode_pin;
    mode_r      <= mode_meta_r;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      link_six_r        <= `LRP_RST_LINK_SIX;
      link_seven_r      <= `LRP_RST_LINK_SEVEN;
      pwr_opt_r         <= `LRP_RST_ZERO;
      buffer_mgmt_reg_a <= `LRP_RST_ZERO;
      buffer_mgmt_reg_b <= `LRP_RST_ZERO;
      ccr_zero_r        <= `LRP_RST_ZERO;
      ccr_one_r         <= `LRP_RST_ZERO;
    end
    else
    begin
      link_six_r        <= link_six_nxt;
      link_seven_r      <= link_seven_nxt;
      pwr_opt_r         <= pwr_opt_nxt;
      buffer_mgmt_reg_a <= bm_a_nxt;
      buffer_mgmt_reg_b <= bm_b_nxt;
      ccr_zero_r        <= ccr_zero_nxt;
      ccr_one_r         <= ccr_one_nxt;
    end
  end

  // a single-cycle reset write is stretched so downstream logic sees a real pulse
  always_ff @(posedge clock)
  begin
    if (srst)
      init_cnt_r <= 8'(INIT_PULSE_CYC);
    else if (ctrl_rst)
      init_cnt_r <= 8'(INIT_PULSE_CYC);
    else if (init_cnt_r != 8'h00)
      init_cnt_r <= init_cnt_r - 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      lan_ctrl_init   <= 1'b1;
      xcvr_init       <= 1'b1;
      xcvr_power_down <= 1'b1;
      card_cfg_init   <= 1'b1;
    end
    else
    begin
      lan_ctrl_init   <= init_act | hold | ~cstat.clk_stable;
      xcvr_init       <= init_act | ~cstat.clk_stable;
      // stays down until the clocks are stable again, also while waking
      xcvr_power_down <= hold | low_pwr | ~cstat.clk_stable;
      card_cfg_init   <= full_rst;
    end
  end

  // memory interface after any full reset; I/O interface once the host configures the card
  always_ff @(posedge clock)
  begin
    if (srst)
      mem_card_if_sel <= 1'b1;
    else if (full_rst)
      mem_card_if_sel <= 1'b1;
    else if (wreq.en & wa_card_config_reg_zero & is_card & ~wreq.data[`LRP_BIT_CARD_SOFT_RESET])
      mem_card_if_sel <= 1'b0;
  end

  assign io_card_sel = ~mem_card_if_sel;

  // status only: the host must itself respect the start-up wait
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      start_cnt_r   <= 13'(STARTUP_CYC);
      startup_ready <= 1'b0;
    end
    else if (init_act | ~cstat.clk_stable)
    begin
      start_cnt_r   <= 13'(STARTUP_CYC);
      startup_ready <= 1'b0;
    end
    else if (start_cnt_r != 13'h0000)
      start_cnt_r <= start_cnt_r - 13'h0001;
    else
      startup_ready <= 1'b1;
  end

  wire [31:0] status_word = {18'h00000, startup_ready, io_card_sel, xcvr_power_down,
                             lan_ctrl_init, cstat.clk_stable, cstat.osc_run,
                             cstat.clk_run, cstat.state[4:0], mode_r};

  assign rd_data = hit(rd_addr, `LRP_OFF_LINK_SIX)   ? {24'h000000, link_six_r}
                 : hit(rd_addr, `LRP_OFF_LINK_SEVEN) ? {24'h000000, link_seven_r}
                 : hit(rd_addr, `LRP_OFF_PWR_OPT)    ? {24'h000000, pwr_opt_r}
                 : hit(rd_addr, `LRP_OFF_BM_A)       ? {24'h000000, buffer_mgmt_reg_a}
                 : hit(rd_addr, `LRP_OFF_BM_B)       ? {24'h000000, buffer_mgmt_reg_b}
                 : hit(rd_addr, `LRP_OFF_CCR_ZERO)   ? {24'h000000, ccr_zero_r}
                 : hit(rd_addr, `LRP_OFF_CCR_ONE)    ? {24'h000000, ccr_one_r}
                 : hit(rd_addr, `LRP_OFF_STATUS)     ? status_word
                 : 32'h0000_0000;

endmodule : lrp_top

// ===== dv/lrp_chk.sv
// port-level assertions for the reset/power block
module lrp_chk (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       lan_ctrl_init,
  input wire logic       xcvr_init,
  input wire logic       xcvr_power_down,
  input wire logic       card_cfg_init,
  input wire logic       mem_card_if_sel,
  input wire logic       osc_enable,
  input wire logic       clk_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  AST_INIT_PAIR: assert property (xcvr_init |-> lan_ctrl_init)
    else $error("transceiver init without controller init");
  AST_GATED_PD: assert property (!clk_enable ##1 !clk_enable |-> xcvr_power_down)
    else $error("transceiver powered while clocks stopped");
  AST_OSC_CLK: assert property (!osc_enable |-> !clk_enable)
    else $error("clocks running without oscillator");
  AST_OSC_FIRST: assert property ($rose(osc_enable) |-> !clk_enable)
    else $error("clocks released with oscillator");
  AST_CLK_INIT: assert property ($rose(clk_enable) |=> lan_ctrl_init)
    else $error("controller left reset before clocks settled");
  AST_CARD_MEM: assert property (card_cfg_init |=> mem_card_if_sel)
    else $error("card reset kept the io interface");
  AST_B_READY: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open during response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_READY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during read data");
endmodule : lrp_chk

// ===== dv/lrp_host_model.sv
// host-side AXI4-Lite master model for the register bus
module lrp_host_model (
  input  wire logic        clock,
  input  wire logic        startup_ready,
  output logic [7:0]       s_axi_awaddr  = 8'h00,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata   = 32'h0,
  output logic [3:0]       s_axi_wstrb   = 4'h0,
  output logic             s_axi_wvalid  = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready  = 1'b0,
  output logic [7:0]       s_axi_araddr  = 8'h00,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_open;
    bit w_open;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    while (aw_open || w_open)
    begin
      @(posedge clock);
      if (aw_open && s_axi_awready === 1'b1)
      begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1)
      begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge clock);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge clock);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // normal operation only after the start-up wait
  task automatic wait_ready();
    do
      @(posedge clock);
    while (startup_ready !== 1'b1);
  endtask : wait_ready
endmodule : lrp_host_model

// ===== dv/test_lan_reset_power_control.sv
// self-checking bench for the reset/power block
module test_lan_reset_power_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  bus_mode_pin = 2'h0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, buffer_mgmt_reg_a, buffer_mgmt_reg_b;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        lan_ctrl_init, xcvr_init, xcvr_power_down, card_cfg_init, mem_card_if_sel;
  logic        osc_enable, clk_enable, startup_ready;
  wire  [6:0]  outs = {mem_card_if_sel, card_cfg_init, xcvr_init, startup_ready,
                       clk_enable, osc_enable, lan_ctrl_init};
  logic [15:0] seed = 16'h51D2;
  int          failures = 0;
  int          n_compared = 0;
  int          m [int];
  // short counts keep the run brief
  lrp_top #(.STARTUP_CYC(20), .OSC_SETTLE_CYC(3), .INIT_PULSE_CYC(2)) i_lrp_top (.*);
  lrp_host_model i_lrp_host_model (.*);
  initial forever #25 clock = ~clock;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for one output to reach a level
  task automatic wt(input int sel, input logic val);
    for (int i = 0; i < 200 && outs[sel] !== val; i++)
      @(posedge clock);
  endtask : wt
  task automatic m_reset(input bit keep_bm);
    int a;
    int b;
    a = keep_bm ? m[16] : 0;
    b = keep_bm ? m[20] : 0;
    m.delete();
    m[0] = 0;
    m[4] = 'h80;
    m[8] = 'h20;
    m[12] = 0;
    m[16] = a;
    m[20] = b;
    m[24] = 0;
    m[28] = 0;
  endtask : m_reset
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_lrp_host_model.wr(a, {24'h0, d}, r);
    check("bresp", r, er);
    if (er != 2'h0)
      return;
    if (a >= 8'h40)
      m_reset(1'b1);
    else if ((a == 8'h00 && d[0]) || (a == 8'h18 && d[7]))
      m_reset(1'b0);
    if (a == 8'h1C)
      m[8][5] = ~d[2];
    if (a != 8'h00 && a < 8'h40)
      m[a] = d;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_lrp_host_model.rd(a, d, r);
    check("rresp", r, er);
    check("rdata", d, (er == 2'h0) ? m[a] : 0);
  endtask : bus_rd
  initial
  begin
    m_reset(1'b0);
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    bus_rd(8'h04, 2'h0);
    bus_rd(8'h08, 2'h0);
    check("hold_init", lan_ctrl_init, 1'b1);
    check("hold_pd", xcvr_power_down, 1'b1);
    seed = lfsr(seed);
    bus_wr(8'h10, seed[7:0], 2'h0);
    bus_wr(8'h14, seed[15:8], 2'h0);
    bus_wr(8'h04, 8'h00, 2'h0);
    wt(0, 1'b0);
    check("run_pd", xcvr_power_down, 1'b0);
    i_lrp_host_model.wait_ready();
    bus_wr(8'h04, 8'h80, 2'h0);
    wt(0, 1'b1);
    check("hold_pd", xcvr_power_down, 1'b1);
    bus_rd(8'h10, 2'h0);
    for (int k = 0; k < 8; k++)
    begin
      bus_wr(8'h04, 8'h00, 2'h0);
      wt(0, 1'b0);
      seed = lfsr(seed);
      bus_wr(8'h40 + 8'(4 * k), seed[7:0], 2'h0);
      wt(0, 1'b1);
      check("port_init", lan_ctrl_init, 1'b1);
      check("port_bm_a", buffer_mgmt_reg_a, m[16]);
      check("port_bm_b", buffer_mgmt_reg_b, m[20]);
    end
    bus_rd(8'h04, 2'h0);
    bus_wr(8'h04, 8'h00, 2'h0);
    bus_wr(8'h00, 8'hFE, 2'h0);
    bus_rd(8'h04, 2'h0);
    bus_wr(8'h00, 8'h01, 2'h0);
    wt(4, 1'b1);
    check("ext_xcvr", xcvr_init, 1'b1);
    check("ext_ready", startup_ready, 1'b0);
    bus_rd(8'h10, 2'h0);
    bus_rd(8'h30, 2'h2);
    bus_wr(8'h18, 8'h80, 2'h2);
    bus_wr(8'h08, 8'h00, 2'h0);
    wt(2, 1'b0);
    check("low_power_request_n_osc", osc_enable, 1'b1);
    bus_wr(8'h08, 8'h20, 2'h0);
    wt(2, 1'b1);
    check("wake_clk", clk_enable, 1'b1);
    check("wake_xinit", xcvr_init, 1'b1);
    bus_wr(8'h0C, 8'h10, 2'h0);
    bus_wr(8'h08, 8'h00, 2'h0);
    wt(1, 1'b0);
    check("shut_clk", clk_enable, 1'b0);
    bus_wr(8'h08, 8'h20, 2'h0);
    wt(2, 1'b1);
    check("shut_osc", osc_enable, 1'b1);
    bus_wr(8'h0C, 8'h00, 2'h0);
    bus_mode_pin <= 2'h1;
    repeat (3) @(posedge clock);
    bus_wr(8'h40, 8'h00, 2'h2);
    bus_mode_pin <= 2'h2;
    repeat (3) @(posedge clock);
    // power state changes only through the card power-down bit
    bus_wr(8'h1C, 8'h04, 2'h0);
    wt(2, 1'b0);
    bus_rd(8'h08, 2'h0);
    bus_wr(8'h1C, 8'h00, 2'h0);
    wt(2, 1'b1);
    bus_rd(8'h08, 2'h0);
    bus_wr(8'h18, 8'h00, 2'h0);
    wt(6, 1'b0);
    seed = lfsr(seed);
    bus_wr(8'h10, seed[7:0], 2'h0);
    bus_wr(8'h18, 8'h80, 2'h0);
    wt(6, 1'b1);
    check("sr_cfg", card_cfg_init, 1'b1);
    check("sr_bm", buffer_mgmt_reg_a, m[16]);
    bus_rd(8'h18, 2'h0);
    // the write that ends the soft reset is still inside it; a second one selects I/O
    bus_wr(8'h18, 8'h00, 2'h0);
    bus_wr(8'h18, 8'h00, 2'h0);
    wt(6, 1'b0);
    check("io_sel", mem_card_if_sel, 1'b0);
    bus_wr(8'h00, 8'h01, 2'h0);
    wt(6, 1'b1);
    check("ext_mem", mem_card_if_sel, 1'b1);
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    wrap_up();
  end
endmodule : test_lan_reset_power_control
bind lrp_top lrp_chk i_lrp_chk (.*);
